// *** scm_clock_ctrl.sv ***
// system clock source, divider and low-power mode controller
`timescale 1ns/1ps
module scm_clock_ctrl (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_b,
    // avalon-mm slave
    input  wire logic [3:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic [31:0]            avs_readdata,
    output logic                   avs_waitrequest,
    // processor core
    input  wire logic              halt_req,
    input  wire logic              wake_req,
    input  wire logic              wdt_enable,
    // clock consumers
    output scm_pkg::scm_gates_t    gates
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]          sel;
        logic                fkeep;
        logic                skeep;
        logic                fen;
        logic                stable;
        logic [15:0]         settle_cnt;
        logic [2:0]          act_sel;
        logic [2:0]          sw_cnt;
        scm_pkg::scm_mode_t  mode;
        logic                waitreq;
        logic [31:0]         rdata;
        scm_pkg::scm_gates_t gates;
    } scm_st_t;

    scm_st_t    s_r;
    scm_st_t    s_nxt;
    logic       cur_tick;
    logic       slow_tick;
    logic       fast_run;
    logic       req;
    logic       done;
    logic       wr_ok;
    logic [7:0] wbyte;
    logic [7:0] ctrl_rd;
    logic [7:0] foc_rd;
    logic [7:0] stat_rd;

    // ----------------------------------------------------------------
    // fast oscillator running
    // ----------------------------------------------------------------
    always_comb begin
        fast_run = 1'b0;
        unique case (s_r.mode)
            scm_pkg::SCM_RUN: begin
                // RULE4 fast source forced on
                if (!scm_pkg::is_slow(s_r.act_sel) || !scm_pkg::is_slow(s_r.sel)) begin
                    fast_run = 1'b1;
                end else begin
                    // RULE5 fast per enable
                    // RULE17 enable gates oscillator
                    fast_run = s_r.fen;
                end
            end
            scm_pkg::SCM_IDLE_BOTH_CLOCKS,
            scm_pkg::SCM_IDLE_FAST_ONLY: begin
                fast_run = 1'b1;
            end
            scm_pkg::SCM_SLEEP,
            scm_pkg::SCM_IDLE_SLOW_ONLY: begin
                fast_run = 1'b0;
            end
            default: begin
                fast_run = 1'b0;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    scm_clk_div u_div (
        .clk       (clk),
        .rst_b     (rst_b),
        .fast_run  (fast_run),
        .sel       (s_r.act_sel),
        .cur_tick  (cur_tick),
        .slow_tick (slow_tick)
    );

    // ----------------------------------------------------------------
    // register read views
    // ----------------------------------------------------------------
    always_comb begin
        // RULE15 unused bits zero
        ctrl_rd = 8'h00;
        ctrl_rd[scm_pkg::CTRL_SEL_LSB +: 3] = s_r.sel;
        ctrl_rd[scm_pkg::CTRL_FKEEP_BIT]    = s_r.fkeep;
        ctrl_rd[scm_pkg::CTRL_SKEEP_BIT]    = s_r.skeep;
        // RULE16 unused bits zero
        foc_rd = 8'h00;
        foc_rd[scm_pkg::FOC_EN_BIT]         = s_r.fen;
        foc_rd[scm_pkg::FOC_STB_BIT]        = s_r.stable;
        stat_rd = {s_r.sw_cnt[1:0], s_r.act_sel, s_r.mode};
    end

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    always_comb begin
        req   = avs_read || avs_write;
        done  = req && !s_r.waitreq;
        wr_ok = avs_write && done && avs_byteenable[0];
        wbyte = avs_writedata[7:0];
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // answer one cycle after the request, release after the finish
        if (done) begin
            s_nxt.waitreq = 1'b1;
        end else if (req) begin
            s_nxt.waitreq = 1'b0;
            if (avs_read) begin
                unique case (avs_address)
                    scm_pkg::OFF_CTRL: s_nxt.rdata = {24'h000000, ctrl_rd};
                    scm_pkg::OFF_FOC:  s_nxt.rdata = {24'h000000, foc_rd};
                    scm_pkg::OFF_STAT: s_nxt.rdata = {24'h000000, stat_rd};
                    default:           s_nxt.rdata = 32'h00000000;
                endcase
            end
        end

        // control and fast oscillator register writes
        if (wr_ok && avs_address == scm_pkg::OFF_CTRL) begin
            s_nxt.sel   = wbyte[scm_pkg::CTRL_SEL_LSB +: 3];
            // RULE11 fast keep bit
            s_nxt.fkeep = wbyte[scm_pkg::CTRL_FKEEP_BIT];
            // RULE12 slow keep bit
            s_nxt.skeep = wbyte[scm_pkg::CTRL_SKEEP_BIT];
        end
        if (wr_ok && avs_address == scm_pkg::OFF_FOC) begin
            // RULE17 enable bit write
            s_nxt.fen = wbyte[scm_pkg::FOC_EN_BIT];
        end

        // settle counter for the stable flag
        if (!s_nxt.fen) begin
            // RULE18 flag low while disabled
            s_nxt.settle_cnt = 16'h0000;
            s_nxt.stable     = 1'b0;
        end else if (!s_r.fen) begin
            // RULE14 rising enable clears flag
            s_nxt.settle_cnt = 16'h0000;
            s_nxt.stable     = 1'b0;
        end else if (!s_r.stable) begin
            // RULE18 counter expiry sets flag
            s_nxt.settle_cnt = s_r.settle_cnt + 16'h0001;
            if (s_r.settle_cnt == scm_pkg::SETTLE_LAST) begin
                s_nxt.stable = 1'b1;
            end
        end

        // clock switch after four current clock periods
        if (s_r.sel == s_r.act_sel) begin
            s_nxt.sw_cnt = 3'h0;
        end else if (cur_tick) begin
            // RULE13 switch delay
            if (s_r.sw_cnt == scm_pkg::SW_LAST) begin
                s_nxt.act_sel = s_r.sel;
                s_nxt.sw_cnt  = 3'h0;
            end else begin
                s_nxt.sw_cnt = s_r.sw_cnt + 3'h1;
            end
        end

        // operating mode
        unique case (s_r.mode)
            scm_pkg::SCM_RUN: begin
                if (halt_req) begin
                    // RULE19 halt pulse latches mode
                    s_nxt.mode = scm_pkg::halt_mode(s_r.fkeep, s_r.skeep);
                end
            end
            scm_pkg::SCM_SLEEP,
            scm_pkg::SCM_IDLE_SLOW_ONLY,
            scm_pkg::SCM_IDLE_BOTH_CLOCKS,
            scm_pkg::SCM_IDLE_FAST_ONLY: begin
                // RULE19 wake pulse resumes
                if (wake_req) begin
                    s_nxt.mode = scm_pkg::SCM_RUN;
                end
            end
            default: begin
                s_nxt.mode = scm_pkg::SCM_RUN;
            end
        endcase

        // clock gates from the present mode
        s_nxt.gates.fast_clk_on = fast_run;
        s_nxt.gates.cpu_run     = 1'b0;
        s_nxt.gates.low_clk_on  = 1'b0;
        s_nxt.gates.wdt_clk_on  = 1'b1;
        s_nxt.gates.sys_clk_on  = 1'b0;
        unique case (s_r.mode)
            scm_pkg::SCM_RUN: begin
                // RULE4 run with all clocks in fast mode
                // RULE5 low clock stays on
                s_nxt.gates.cpu_run    = 1'b1;
                s_nxt.gates.low_clk_on = 1'b1;
                s_nxt.gates.sys_clk_on = 1'b1;
            end
            scm_pkg::SCM_SLEEP: begin
                // RULE6 sleep stops clocks
                s_nxt.gates.low_clk_on = 1'b0;
                // RULE7 wdt clock follows enable
                s_nxt.gates.wdt_clk_on = wdt_enable;
            end
            scm_pkg::SCM_IDLE_SLOW_ONLY: begin
                // RULE8 idle on low clock
                s_nxt.gates.low_clk_on = 1'b1;
                s_nxt.gates.sys_clk_on = scm_pkg::is_slow(s_r.act_sel);
            end
            scm_pkg::SCM_IDLE_BOTH_CLOCKS: begin
                // RULE9 idle with both clocks
                s_nxt.gates.low_clk_on = 1'b1;
                s_nxt.gates.sys_clk_on = 1'b1;
            end
            scm_pkg::SCM_IDLE_FAST_ONLY: begin
                // RULE10 idle on fast clock
                s_nxt.gates.low_clk_on = 1'b0;
                s_nxt.gates.sys_clk_on = !scm_pkg::is_slow(s_r.act_sel);
            end
            default: begin
                s_nxt.gates.low_clk_on = 1'b0;
            end
        endcase

        // RULE1 system clock tick
        s_nxt.gates.sys_tick = cur_tick && s_nxt.gates.sys_clk_on;
        // RULE3 low clock tick
        s_nxt.gates.low_tick = slow_tick && s_nxt.gates.low_clk_on;
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // RULE15 control resets zero
            s_r.sel              <= scm_pkg::SEL_RST;
            s_r.fkeep            <= scm_pkg::FKEEP_RST;
            s_r.skeep            <= scm_pkg::SKEEP_RST;
            // RULE16 enable one, flag zero
            s_r.fen              <= scm_pkg::FEN_RST;
            s_r.stable           <= scm_pkg::STB_RST;
            s_r.settle_cnt       <= 16'h0000;
            s_r.act_sel          <= scm_pkg::SEL_RST;
            s_r.sw_cnt           <= 3'h0;
            s_r.mode             <= scm_pkg::SCM_RUN;
            s_r.waitreq          <= 1'b1;
            s_r.rdata            <= 32'h00000000;
            s_r.gates.cpu_run    <= 1'b1;
            s_r.gates.fast_clk_on <= 1'b1;
            s_r.gates.low_clk_on <= 1'b1;
            s_r.gates.wdt_clk_on <= 1'b1;
            s_r.gates.sys_clk_on <= 1'b1;
            s_r.gates.sys_tick   <= 1'b0;
            s_r.gates.low_tick   <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    always_comb begin
        avs_readdata    = s_r.rdata;
        avs_waitrequest = s_r.waitreq;
        gates           = s_r.gates;
    end

endmodule // scm_clock_ctrl

// *** scm_pkg.sv ***
// constants, types and helpers of the system clock mode control block
//
// Operation
// RULE1 - select code picks divided fast or low clock
// RULE2 - fast_clock comes from 20 MHz fast_rc_osc
// RULE3 - low_clock comes from 32 kHz slow_rc_osc
// RULE4 - fast mode keeps all clocks on
// RULE5 - slow mode: low clock, fast per enable
// RULE6 - halt with keeps 00 enters sleep
// RULE7 - sleep keeps wdt clock only if enabled
// RULE8 - halt with keeps 01 enters idle_slow_only
// RULE9 - halt with keeps 11 enters idle_both_clocks
// RULE10 - halt with keeps 10 enters idle_fast_only
// RULE11 - fast_osc_idle_keep bit 1 resets 0
// RULE12 - slow_osc_idle_keep bit 0 resets 0
// RULE13 - clock switch completes within four periods
// RULE14 - enabling fast osc clears then sets stable
// RULE15 - control bits 4..2 read zero, reset zero
// RULE16 - fast osc bits 7..2 zero, enable resets 1
// RULE17 - fast_osc_enable bit 0 gates fast oscillator
// RULE18 - settle counter drives fast_osc_stable
// RULE19 - core pulses halt and wake requests
package scm_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned FAST_HZ     = 20_000_000;
    localparam int unsigned SLOW_HZ     = 32_000;
    localparam int unsigned SLOW_DIV    = FAST_HZ / SLOW_HZ;
    localparam logic [9:0]  SLOW_DIV_M1 = 10'(SLOW_DIV - 1);
    localparam int unsigned SETTLE_NS   = 16_000;
    localparam int unsigned SETTLE_CYC  = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
    localparam logic [2:0]  SW_LAST     = 3'h3;

    // ----------------------------------------------------------------
    // register map and fields
    // ----------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL        = 4'h0;
    localparam logic [3:0] OFF_FOC         = 4'h4;
    localparam logic [3:0] OFF_STAT        = 4'h8;
    localparam int unsigned CTRL_SEL_LSB   = 5;
    localparam int unsigned CTRL_FKEEP_BIT = 1;
    localparam int unsigned CTRL_SKEEP_BIT = 0;
    localparam int unsigned FOC_EN_BIT    = 0;
    localparam int unsigned FOC_STB_BIT   = 1;
    localparam logic [2:0] SEL_RST        = 3'h0;
    localparam logic       FKEEP_RST      = 1'b0;
    localparam logic       SKEEP_RST      = 1'b0;
    localparam logic       FEN_RST        = 1'b1;
    localparam logic       STB_RST        = 1'b0;
    localparam logic [2:0] SEL_SLOW       = 3'h7;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SCM_RUN              = 3'b000,
        SCM_SLEEP            = 3'b001,
        SCM_IDLE_SLOW_ONLY   = 3'b010,
        SCM_IDLE_BOTH_CLOCKS = 3'b011,
        SCM_IDLE_FAST_ONLY   = 3'b100
    } scm_mode_t;

    typedef struct packed {
        logic cpu_run;
        logic fast_clk_on;
        logic low_clk_on;
        logic wdt_clk_on;
        logic sys_clk_on;
        logic sys_tick;
        logic low_tick;
    } scm_gates_t;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic scm_mode_t halt_mode(input logic fkeep, input logic skeep);
        unique case ({fkeep, skeep})
            2'b00: halt_mode = SCM_SLEEP;
            2'b01: halt_mode = SCM_IDLE_SLOW_ONLY;
            2'b11: halt_mode = SCM_IDLE_BOTH_CLOCKS;
            2'b10: halt_mode = SCM_IDLE_FAST_ONLY;
        endcase
    endfunction

    function automatic logic is_slow(input logic [2:0] sel);
        is_slow = (sel == SEL_SLOW);
    endfunction

endpackage

// *** scm_clk_div.sv ***
// divider giving ticks of fast_clock by 1..64 and of low_clock
`timescale 1ns/1ps
module scm_clk_div (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // control
    input  wire logic       fast_run,
    input  wire logic [2:0] sel,
    // ticks
    output logic            cur_tick,
    output logic            slow_tick
);

    typedef struct packed {
        logic [5:0] fast_cnt;
        logic [9:0] slow_cnt;
    } scm_div_st_t;

    scm_div_st_t s_r;
    scm_div_st_t s_nxt;
    logic [5:0]  mask;
    logic        fast_tick;

    // ----------------------------------------------------------------
    // tick decode
    // ----------------------------------------------------------------
    always_comb begin
        // RULE1 divide ratio
        mask      = 6'((7'h01 << sel[2:0]) - 7'h01);
        // RULE2 fast base
        fast_tick = fast_run && ((s_r.fast_cnt & mask) == mask);
        // RULE3 low clock tick
        slow_tick = (s_r.slow_cnt == scm_pkg::SLOW_DIV_M1);
        cur_tick  = scm_pkg::is_slow(sel) ? slow_tick : fast_tick;
    end

    always_comb begin
        s_nxt = s_r;
        if (fast_run) begin
            s_nxt.fast_cnt = s_r.fast_cnt + 6'h01;
        end
        if (slow_tick) begin
            s_nxt.slow_cnt = 10'h000;
        end else begin
            s_nxt.slow_cnt = s_r.slow_cnt + 10'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

endmodule // scm_clk_div

// *** scm_clock_ctrl_sva.sv ***
// assertion checker for the system clock mode control block
`timescale 1ns/1ps
module scm_clock_ctrl_chk (
    // clock and reset
    input wire logic                clk,
    input wire logic                rst_b,
    // register bus
    input wire logic [3:0]          avs_address,
    input wire logic                avs_read,
    input wire logic                avs_write,
    input wire logic [31:0]         avs_writedata,
    input wire logic [3:0]          avs_byteenable,
    input wire logic [31:0]         avs_readdata,
    input wire logic                avs_waitrequest,
    // core and clock consumers
    input wire logic                halt_req,
    input wire logic                wake_req,
    input wire logic                wdt_enable,
    input wire scm_pkg::scm_gates_t gates
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic asleep;
    logic rd_done;
    assign asleep  = !gates.cpu_run && !gates.fast_clk_on && !gates.low_clk_on;
    assign rd_done = avs_read && !avs_waitrequest;
    a_ctrl_zero_bits: assert property (rd_done && avs_address == 4'h0 |->
        avs_readdata[4:2] == 3'h0 && avs_readdata[31:8] == 24'h0) else $error("ctrl pad bits");
    a_osc_zero_bits: assert property (rd_done && avs_address == 4'h4 |->
        avs_readdata[31:2] == 30'h0) else $error("osc pad bits");
    a_halt_stops_cpu: assert property (halt_req && gates.cpu_run |-> ##2 !gates.cpu_run)
        else $error("cpu still running after halt");
    a_wake_starts_cpu: assert property (wake_req && !gates.cpu_run |-> ##2 gates.cpu_run)
        else $error("cpu not running after wake");
    a_sleep_wdt_clock: assert property (asleep |-> gates.wdt_clk_on == $past(wdt_enable))
        else $error("wdt clock wrong in sleep");
    a_sleep_no_sys: assert property (asleep |-> !gates.sys_clk_on && !gates.sys_tick)
        else $error("system clock runs in sleep");
    a_idle_fast_low: assert property (!gates.cpu_run && gates.fast_clk_on && !gates.low_clk_on
        |-> gates.wdt_clk_on && !gates.low_tick) else $error("idle fast clocks");
    a_run_clocks_on: assert property (gates.cpu_run && $past(gates.cpu_run) |->
        gates.low_clk_on && gates.wdt_clk_on && gates.sys_clk_on) else $error("run clock off");
    a_low_tick_pulse: assert property (gates.low_tick |=> !gates.low_tick)
        else $error("low tick too long");
    c_sleep: cover property (asleep);
    c_idle_fast: cover property (!gates.cpu_run && gates.fast_clk_on && !gates.low_clk_on);
    c_ctrl_read: cover property (rd_done && avs_address == 4'h0);
endmodule // scm_clock_ctrl_chk

bind scm_clock_ctrl scm_clock_ctrl_chk u_chk (.clk(clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .halt_req(halt_req),
    .wake_req(wake_req), .wdt_enable(wdt_enable), .gates(gates));

// *** scm_core_model.sv ***
// processor core model issuing halt and wake pulses
`timescale 1ns/1ps
module scm_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // commands from the bench
    input wire logic go_halt,
    input wire logic go_wake,
    // requests to the block
    output logic     halt_req,
    output logic     wake_req
);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            halt_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            halt_req <= go_halt && !halt_req;
            wake_req <= go_wake && !wake_req;
        end
    end
endmodule // scm_core_model

// *** scm_clock_ctrl_tb.sv ***
// self-checking testbench of the system clock mode control block
`timescale 1ns/1ps
module scm_clock_ctrl_tb;
    logic                clk = 1'b0;
    logic                rst_b = 1'b0;
    logic [3:0]          avs_address = 4'h0;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_writedata = 32'h0;
    logic [3:0]          avs_byteenable = 4'hf;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic                go_halt = 1'b0;
    logic                go_wake = 1'b0;
    logic                halt_req;
    logic                wake_req;
    logic                wdt_enable = 1'b1;
    scm_pkg::scm_gates_t gates;
    logic [63:0]         exp_q[$];
    int                  miscompares = 0;
    int                  n_compared = 0;

    always #25 clk = ~clk;

    scm_core_model u_core (.clk(clk), .rst_b(rst_b), .go_halt(go_halt), .go_wake(go_wake),
        .halt_req(halt_req), .wake_req(wake_req));
    scm_clock_ctrl DUT (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .halt_req(halt_req), .wake_req(wake_req), .wdt_enable(wdt_enable), .gates(gates));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address   <= a;
        avs_read      <= !wr;
        avs_write     <= wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 50) begin
            miscompares++;
            stop_test();
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e});
        bus(1'b0, a, 32'h0);
    endtask

    // measures cycles between two pulses of gate bit b
    task automatic gap(input int b, output int n);
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (gates[b] !== 1'b1 && k < 700);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (gates[b] !== 1'b1 && n < 700);
        if (k >= 700 || n >= 700) begin
            miscompares++;
            stop_test();
        end
    endtask

    task automatic halt_chk(input logic [4:0] e);
        @(posedge clk);
        go_halt <= 1'b1;
        @(posedge clk);
        go_halt <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(gates[6:2]), 32'(e));
        go_wake <= 1'b1;
        @(posedge clk);
        go_wake <= 1'b0;
        repeat (4) @(posedge clk);
        chk(32'(gates.cpu_run), 32'h1);
    endtask

    // read monitor: oldest note against returned data
    always @(posedge clk) begin
        logic [63:0] e;
        if (avs_read && avs_waitrequest === 1'b0) begin
            e = exp_q.pop_front();
            chk(avs_readdata & e[63:32], e[31:0]);
        end
    end

    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        logic [2:0]  sel;
        int          n;
        int          per;
        void'($urandom(32'h8a48));
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        rd(4'h0, 32'h0, 32'hffff_ffff);
        rd(4'h4, 32'h1, 32'hffff_ffff);
        rd(4'hc, 32'h0, 32'hffff_ffff);
        $display("test reset values done");
        repeat (330) @(posedge clk);
        rd(4'h4, 32'h3, 32'hffff_ffff);
        bus(1'b1, 4'h4, 32'h0);
        rd(4'h4, 32'h0, 32'hffff_ffff);
        bus(1'b1, 4'h4, 32'h1);
        rd(4'h4, 32'h1, 32'hffff_ffff);
        repeat (330) @(posedge clk);
        rd(4'h4, 32'h3, 32'hffff_ffff);
        $display("test oscillator settle done");
        r = $urandom & 32'hffff_ff1f;
        bus(1'b1, 4'h0, r);
        rd(4'h0, r & 32'he3, 32'hffff_ffff);
        avs_byteenable <= 4'he;
        bus(1'b1, 4'h0, 32'h0);
        avs_byteenable <= 4'hf;
        rd(4'h0, r & 32'he3, 32'hffff_ffff);
        $display("test control bits done");
        per = 1;
        for (int s = 0; s < 8; s++) begin
            bus(1'b1, 4'h0, {24'h0, 3'(s), 5'h0});
            repeat (4 * per + 4) @(posedge clk);
            rd(4'h8, {26'h0, 3'(s), 3'h0}, 32'h38);
            per = (s == 7) ? 625 : (1 << s);
            gap(1, n);
            chk(32'(n), 32'(per));
        end
        $display("test clock select done");
        bus(1'b1, 4'h4, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(gates.fast_clk_on), 32'h0);
        bus(1'b1, 4'h4, 32'h1);
        repeat (3) @(posedge clk);
        chk(32'(gates.fast_clk_on), 32'h1);
        gap(0, n);
        chk(32'(n), scm_pkg::SLOW_DIV);
        $display("test slow mode done");
        for (int i = 0; i < 2; i++) begin
            sel = (i == 1) ? 3'h7 : 3'h0;
            bus(1'b1, 4'h0, {24'h0, sel, 5'h0});
            repeat (2600) @(posedge clk);
            for (int k = 0; k < 4; k++) begin
                r = $urandom;
                wdt_enable <= r[0];
                bus(1'b1, 4'h0, {24'h0, sel, 3'h0, 2'(k)});
                halt_chk({1'b0, k[1], k[0], (k[1] | k[0]) ? 1'b1 : r[0],
                    (k[1] & k[0]) | (k[0] & (sel == 3'h7)) | (k[1] & (sel != 3'h7))});
            end
        end
        $display("test halt modes done");
        stop_test();
    end
endmodule // scm_clock_ctrl_tb
